// file: interrupt_level_priority_ctrl.sv
// Purpose: System-level interrupt controller: levels, priority, vectors.
// Assumes: Program memory returns read data one cycle after the read.
// Notes:   A grant runs push, two vector byte reads, then a program counter load.
//
// Operation
// - Eight levels zero to seven, each one request line.
// - Level number gives no priority; the priority register alone orders levels.
// - Levels 0-1 group A, 2-4 group B, 5-7 group C.
// - Inside a level the lowest vector address wins.
// - Twenty-six sources, each with its own vector.
// - Each level has one vector per source; levels with several sources have several vectors.
// - Source pending cleared by hardware at service start for sources 0-3, otherwise by software.
// - A grant disables interrupts and pushes program counter and flags.
// - Handler address is vector byte joined with following byte.
// - All vectors lie in the lowest 256 bytes of program memory.
// - After reset execution starts at address 0100H.
// - Enable instruction sets, disable instruction clears, mode bit 0.
// - With global enable, unmasked pending requests are served by priority.
// - Mask register read and write; a masked level is not served.
// - Read-only level pending register, one bit per level.
// - Mode register also holds fast interrupt controls.
// - Each source is gated by its own enable bit.
// - Mask bit n is level n; one enables, zero blocks.
// - Reset clears mode bits 1 and 0.
// - Mask and priority must be set by software before enabling.

`timescale 1ns/1ps

module interrupt_level_priority_ctrl (
	input  wire logic                                    clk_i,
	input  wire logic                                    reset_i,
	input  wire logic [7:0]                              reg_addr_i,
	input  wire logic [7:0]                              reg_wdata_i,
	input  wire logic                                    reg_wr_i,
	input  wire logic                                    reg_rd_i,
	output logic      [7:0]                              reg_rdata_o,
	input  wire logic [int_ctrl_pkg::SRC_COUNT-1:0]      src_req_i,
	input  wire logic                                    global_int_on_instr_i,
	input  wire logic                                    global_int_off_instr_i,
	output logic                                         irq_o,
	input  wire logic                                    ack_i,
	output logic                                         push_stack_o,
	output logic                                         mem_rd_o,
	output logic      [15:0]                             mem_addr_o,
	input  wire logic [7:0]                              mem_data_i,
	output logic                                         pc_load_o,
	output logic      [15:0]                             pc_value_o,
	output logic      [int_ctrl_pkg::LEVEL_COUNT-1:0]    level_request_o,
	output logic                                         global_enable_o,
	output logic                                         fast_enable_o,
	output logic      [2:0]                              fast_level_o
);
	import int_ctrl_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {ST_BOOT, ST_IDLE, ST_PUSH, ST_FETCH_HI, ST_FETCH_LO,
		ST_WAIT} ctrl_state_type;

	typedef struct packed {
		ctrl_state_type         state;
		logic [MODE_WIDTH-1:0]  mode;
		logic [7:0]             mask;
		logic [7:0]             prio;
		logic [SRC_COUNT-1:0]   src_en;
		logic [SRC_COUNT-1:0]   src_pend;
		logic [7:0]             rdata;
		logic [7:0]             vector;
		logic [15:0]            fetch_addr;
		logic [7:0]             handler_hi;
		logic [15:0]            pc_value;
		logic                   pc_load;
	} regs_type;

	regs_type q;
	regs_type d;

	logic [SRC_COUNT-1:0]   src_active;
	logic [LEVEL_COUNT-1:0] level_any;
	logic [4:0]             level_src [LEVEL_COUNT];
	logic [LEVEL_COUNT-1:0] level_req;
	logic                   win_found;
	logic [2:0]             win_level;
	logic [4:0]             win_src;
	logic                   accept;

	// ----------------------------------------------------------------
	// Priority ranking
	// ----------------------------------------------------------------

	// Rank of a group (0 A, 1 B, 2 C) under the group order select.
	function automatic logic [1:0] group_rank(input logic [2:0] sel, input logic [1:0] grp);
		logic [5:0] ranks;
		ranks = 6'b00_01_10;
		case (sel)
			3'h1:    ranks = 6'b00_10_01;
			3'h2:    ranks = 6'b01_00_10;
			3'h3:    ranks = 6'b10_00_01;
			3'h4:    ranks = 6'b01_10_00;
			3'h5:    ranks = 6'b10_01_00;
			default: ranks = 6'b00_01_10;
		endcase
		case (grp)
			2'h0:    group_rank = ranks[5:4];
			2'h1:    group_rank = ranks[3:2];
			default: group_rank = ranks[1:0];
		endcase
	endfunction

	// Rotates a three-member group by the two-bit field; value three acts as zero.
	function automatic logic [1:0] rot3(input logic [1:0] pos, input logic [1:0] rot);
		logic [2:0] sum;
		sum  = 3'(pos) + 3'h3 - 3'((rot == 2'h3) ? 2'h0 : rot);
		rot3 = (sum >= 3'h3) ? 2'(sum - 3'h3) : 2'(sum);
	endfunction

	// Lower rank is served first; the level number enters only through its group and its place in the group.
	function automatic logic [3:0] level_rank(input int lvl, input logic [7:0] prio);
		logic [1:0] grp;
		logic [1:0] sub;
		grp = (lvl < 2) ? 2'h0 : ((lvl < 5) ? 2'h1 : 2'h2);
		if (lvl < 2)
			sub = {1'b0, 1'(lvl) ^ prio[PRIO_A_BIT]};
		else if (lvl < 5)
			sub = rot3(2'(lvl - 2), prio[PRIO_B_LSB +: 2]);
		else
			sub = rot3(2'(lvl - 5), prio[PRIO_C_LSB +: 2]);
		level_rank = 4'(group_rank(prio[PRIO_GROUP_LSB +: 3], grp)) * 4'h3 + 4'(sub);
	endfunction

	// ----------------------------------------------------------------
	// Per-level source selection
	// ----------------------------------------------------------------

	// A source counts only when pending and enabled.
	assign src_active = q.src_pend & q.src_en;

	// Each level picks its own lowest source.
	for (genvar g = 0; g < LEVEL_COUNT; g++)
	begin : gen_level
		level_source_pick #(
			.FIRST (int'(LEVEL_FIRST[g])),
			.COUNT (LEVEL_SIZE[g])
		) u_pick (
			.active_i (src_active),
			.any_o    (level_any[g]),
			.index_o  (level_src[g])
		);
	end

	// Level is requesting when unmasked; global enable gates only irq_o.
	assign level_req = level_any & q.mask;
	assign irq_o     = (q.state == ST_IDLE) && q.mode[MODE_GLOBAL_BIT] && win_found;
	assign accept    = irq_o && ack_i;

	// Picks exactly one level by rank among all requesting levels.
	always_comb
	begin
		logic [3:0] best;
		best      = 4'hf;
		win_found = 1'b0;
		win_level = 3'h0;
		for (int l = 0; l < LEVEL_COUNT; l++)
		begin
			if (level_req[l] && (!win_found || level_rank(l, q.prio) < best))
			begin
				win_found = 1'b1;
				win_level = 3'(l);
				best      = level_rank(l, q.prio);
			end
		end
		win_src = level_src[win_level];
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------

	// Register port, flag updates and the grant sequence.
	always_comb
	begin
		logic [SRC_COUNT-1:0] clr;
		logic [31:0]          wide;
		clr       = '0;
		wide      = '0;
		d         = q;
		d.rdata   = 8'h00;
		d.pc_load = 1'b0;

		// Writes from software.
		if (reg_wr_i)
		begin
			if (reg_addr_i == ADDR_SYSTEM_MODE)
				d.mode = reg_wdata_i[MODE_WIDTH-1:0];
			else if (reg_addr_i == ADDR_LEVEL_MASK)
				d.mask = reg_wdata_i;
			else if (reg_addr_i == ADDR_LEVEL_PRIORITY)
				d.prio = reg_wdata_i;
			else if (reg_addr_i >= ADDR_SRC_ENABLE0 && reg_addr_i < ADDR_SRC_PENDING0)
			begin
				wide                                        = 32'(q.src_en);
				wide[8*(reg_addr_i - ADDR_SRC_ENABLE0) +: 8] = reg_wdata_i;
				d.src_en                                    = wide[SRC_COUNT-1:0];
			end
			else if (reg_addr_i >= ADDR_SRC_PENDING0 &&
				reg_addr_i < ADDR_SRC_PENDING0 + 8'(SRC_REG_COUNT))
			begin
				wide                                          = '0;
				wide[8*(reg_addr_i - ADDR_SRC_PENDING0) +: 8] = reg_wdata_i;
				clr                                           = wide[SRC_COUNT-1:0];
			end
		end

		// Enable and disable instructions; disable wins when both arrive.
		if (global_int_on_instr_i)
			d.mode[MODE_GLOBAL_BIT] = 1'b1;
		if (global_int_off_instr_i)
			d.mode[MODE_GLOBAL_BIT] = 1'b0;

		// Reads return data in the next cycle only; unmapped reads give zero.
		if (reg_rd_i)
		begin
			wide = '0;
			if (reg_addr_i == ADDR_SYSTEM_MODE)
				d.rdata = 8'(q.mode);
			else if (reg_addr_i == ADDR_LEVEL_MASK)
				d.rdata = q.mask;
			else if (reg_addr_i == ADDR_LEVEL_PRIORITY)
				d.rdata = q.prio;
			else if (reg_addr_i == ADDR_LEVEL_PENDING)
				d.rdata = level_any;
			else if (reg_addr_i >= ADDR_SRC_ENABLE0 && reg_addr_i < ADDR_SRC_PENDING0)
			begin
				wide    = 32'(q.src_en);
				d.rdata = wide[8*(reg_addr_i - ADDR_SRC_ENABLE0) +: 8];
			end
			else if (reg_addr_i >= ADDR_SRC_PENDING0 &&
				reg_addr_i < ADDR_SRC_PENDING0 + 8'(SRC_REG_COUNT))
			begin
				wide    = 32'(q.src_pend);
				d.rdata = wide[8*(reg_addr_i - ADDR_SRC_PENDING0) +: 8];
			end
		end

		// Grant sequence.
		case (q.state)
			ST_BOOT:
			begin
				d.pc_value = RESET_PC;
				d.pc_load  = 1'b1;
				d.state    = ST_IDLE;
			end
			ST_IDLE:
			begin
				if (accept)
				begin
					d.mode[MODE_GLOBAL_BIT] = 1'b0;
					d.vector = VECTOR_BASE + {win_src, 1'b0};
					if (AUTO_CLEAR_MASK[win_src])
						clr[win_src] = 1'b1;
					d.state = ST_PUSH;
				end
			end
			ST_PUSH:
			begin
				d.fetch_addr = {8'h00, q.vector};
				d.state      = ST_FETCH_HI;
			end
			ST_FETCH_HI:
			begin
				d.fetch_addr = q.fetch_addr + 16'h0001;
				d.state      = ST_FETCH_LO;
			end
			ST_FETCH_LO:
			begin
				d.handler_hi = mem_data_i;
				d.state      = ST_WAIT;
			end
			ST_WAIT:
			begin
				d.pc_value = {q.handler_hi, mem_data_i};
				d.pc_load  = 1'b1;
				d.state    = ST_IDLE;
			end
			default: d.state = ST_IDLE;
		endcase

		// A new request in the clearing cycle survives the clear.
		d.src_pend = (q.src_pend & ~clr) | src_req_i;
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------

	// Mask and priority are given a defined value although software sets them.
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			q            <= '0;
			q.state      <= ST_BOOT;
			q.mode       <= MODE_RESET;
			q.mask       <= MASK_RESET;
			q.prio       <= PRIO_RESET;
			q.src_en     <= SRC_EN_RESET;
		end
		else
			q <= d;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------

	// Push and read strobes decode the state; pc load and data come from flip-flops.
	assign push_stack_o    = (q.state == ST_PUSH);
	assign mem_rd_o        = (q.state == ST_FETCH_HI) || (q.state == ST_FETCH_LO);
	assign mem_addr_o      = q.fetch_addr;
	assign reg_rdata_o     = q.rdata;
	assign pc_load_o       = q.pc_load;
	assign pc_value_o      = q.pc_value;
	assign level_request_o = level_any;
	assign global_enable_o = q.mode[MODE_GLOBAL_BIT];
	assign fast_enable_o   = q.mode[MODE_FAST_BIT];
	assign fast_level_o    = q.mode[MODE_FLEVEL_LSB +: 3];

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	boot_pc_a: assert property (@(posedge clk_i) $fell(reset_i) |-> ##[0:2]
		(pc_load_o && pc_value_o == RESET_PC)) else $error("reset start address missing");
	irq_gate_a: assert property (@(posedge clk_i) disable iff (reset_i)
		irq_o |-> (global_enable_o && (q.mask & level_any) != 8'h00))
		else $error("request without enable, mask or source");
	ack_disable_a: assert property (@(posedge clk_i) disable iff (reset_i)
		accept |=> !global_enable_o && push_stack_o) else $error("grant left enable set");
	fetch_vector_a: assert property (@(posedge clk_i) disable iff (reset_i)
		accept |=> ##1 (mem_rd_o && mem_addr_o == {8'h00, q.vector})
		##1 (mem_rd_o && mem_addr_o == {8'h00, q.vector} + 16'h0001))
		else $error("vector bytes not fetched in order");
	handler_join_a: assert property (@(posedge clk_i) disable iff (reset_i)
		(pc_load_o && $past(mem_rd_o, 2)) |->
		pc_value_o == {$past(mem_data_i, 2), $past(mem_data_i)})
		else $error("handler address not joined from vector bytes");
	vector_area_a: assert property (@(posedge clk_i) disable iff (reset_i)
		mem_rd_o |-> mem_addr_o[15:8] == 8'h00) else $error("vector outside low page");
	mask_write_a: assert property (@(posedge clk_i) disable iff (reset_i)
		(reg_wr_i && reg_addr_i == ADDR_LEVEL_MASK) |=> q.mask == $past(reg_wdata_i))
		else $error("mask write lost");
	pend_read_a: assert property (@(posedge clk_i) disable iff (reset_i)
		(reg_rd_i && reg_addr_i == ADDR_LEVEL_PENDING) |=> reg_rdata_o == $past(level_any))
		else $error("level pending read wrong");
	instr_on_a: assert property (@(posedge clk_i) disable iff (reset_i)
		(global_int_on_instr_i && !global_int_off_instr_i && !accept) |=> global_enable_o)
		else $error("enable instruction ignored");
	set_wins_a: assert property (@(posedge clk_i) disable iff (reset_i)
		1'b1 |=> (q.src_pend & $past(src_req_i)) == $past(src_req_i))
		else $error("source request lost");

endmodule

// file: int_ctrl_pkg.sv
// Purpose: Shared constants for the level and priority interrupt controller.
// Assumes: Eight-bit register port, byte-wide program memory, one clock.
// Notes:   Offsets are byte addresses on the register port.

package int_ctrl_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int LEVEL_COUNT = 8;
	localparam int SRC_COUNT   = 26;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_SYSTEM_MODE    = 8'h00;
	localparam logic [7:0] ADDR_LEVEL_MASK     = 8'h01;
	localparam logic [7:0] ADDR_LEVEL_PRIORITY = 8'h02;
	localparam logic [7:0] ADDR_LEVEL_PENDING  = 8'h03;
	localparam logic [7:0] ADDR_SRC_ENABLE0    = 8'h04;
	localparam logic [7:0] ADDR_SRC_PENDING0   = 8'h08;
	localparam int         SRC_REG_COUNT       = 4;

	// ----------------------------------------------------------------
	// System mode register fields
	// ----------------------------------------------------------------
	localparam int MODE_GLOBAL_BIT = 0;
	localparam int MODE_FAST_BIT   = 1;
	localparam int MODE_FLEVEL_LSB = 2;
	localparam int MODE_WIDTH      = 5;

	// ----------------------------------------------------------------
	// Level priority register fields
	// ----------------------------------------------------------------
	localparam int PRIO_GROUP_LSB = 0;
	localparam int PRIO_A_BIT     = 3;
	localparam int PRIO_B_LSB     = 4;
	localparam int PRIO_C_LSB     = 6;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [4:0]  MODE_RESET     = 5'h00;
	localparam logic [7:0]  MASK_RESET     = 8'h00;
	localparam logic [7:0]  PRIO_RESET     = 8'h00;
	localparam logic [25:0] SRC_EN_RESET   = 26'h0000000;
	localparam logic [15:0] RESET_PC       = 16'h0100;

	// ----------------------------------------------------------------
	// Source layout and vectors
	// ----------------------------------------------------------------
	localparam logic [4:0]  LEVEL_FIRST [LEVEL_COUNT] = '{5'd0, 5'd3, 5'd4, 5'd6,
		5'd10, 5'd14, 5'd18, 5'd22};
	localparam int          LEVEL_SIZE  [LEVEL_COUNT] = '{3, 1, 2, 4, 4, 4, 4, 4};
	localparam logic [7:0]  VECTOR_BASE     = 8'h40;
	localparam logic [25:0] AUTO_CLEAR_MASK = 26'h000000f;

endpackage

// file: level_source_pick.sv
// Purpose: Picks the lowest-numbered active source inside one level.
// Assumes: Lower source index means lower vector address.
// Notes:   One instance per level.

`timescale 1ns/1ps

module level_source_pick #(
	parameter int FIRST = 0,
	parameter int COUNT = 1
) (
	input  wire logic [int_ctrl_pkg::SRC_COUNT-1:0] active_i,
	output logic                                    any_o,
	output logic      [4:0]                         index_o
);
	import int_ctrl_pkg::*;

	// ----------------------------------------------------------------
	// Fixed in-level order
	// ----------------------------------------------------------------

	// Scans from the top so that the lowest active index is kept last.
	always_comb
	begin
		any_o   = 1'b0;
		index_o = 5'(FIRST);
		for (int i = FIRST + COUNT - 1; i >= FIRST; i--)
		begin
			if (active_i[i])
			begin
				any_o   = 1'b1;
				index_o = 5'(i);
			end
		end
	end

endmodule

// file: cpu_mem_model.sv
// Purpose: Model of the CPU sequencer and program memory beside the controller.
// Assumes: Memory answers one cycle after a read strobe.
// Notes:   Byte at address a holds a xor BYTE_KEY, so handler addresses are predictable.

`timescale 1ns/1ps

module cpu_mem_model #(
	parameter logic [7:0] BYTE_KEY = 8'h5a
) (
	input  wire logic        clk_i,
	input  wire logic        irq_i,
	input  wire logic [3:0]  ack_delay_i,
	output logic             ack_o,
	input  wire logic        mem_rd_i,
	input  wire logic [15:0] mem_addr_i,
	output logic      [7:0]  mem_data_o
);
	logic [3:0] wait_cnt;

	initial
	begin
		ack_o = 1'h0;
		wait_cnt = 4'h0;
		mem_data_o = 8'h00;
	end

	// Acknowledges a waiting request after the chosen delay, as a one-cycle pulse.
	always @(posedge clk_i)
	begin
		if (ack_o || !irq_i)
		begin
			ack_o <= 1'h0;
			wait_cnt <= 4'h0;
		end
		else if (wait_cnt >= ack_delay_i)
			ack_o <= 1'h1;
		else
			wait_cnt <= wait_cnt + 4'h1;
	end

	// Returns the addressed byte one cycle after a read, otherwise a toggling pattern.
	always @(posedge clk_i)
	begin
		if (mem_rd_i)
			mem_data_o <= mem_addr_i[7:0] ^ BYTE_KEY;
		else
			mem_data_o <= ~mem_data_o;
	end
endmodule

// file: testbench.sv
// Purpose: Self-checking bench for the level and priority interrupt controller.
// Assumes: Partner model supplies acknowledge and vector bytes.
// Notes:   Inputs change by non-blocking assignment at the rising edge.

`timescale 1ns/1ps

module testbench;
	import int_ctrl_pkg::*;

	logic        clk_i = 1'h0;
	logic        reset_i = 1'h1;
	logic [7:0]  reg_addr_i = 8'h00;
	logic [7:0]  reg_wdata_i = 8'h00;
	logic        reg_wr_i = 1'h0;
	logic        reg_rd_i = 1'h0;
	logic [7:0]  reg_rdata_o;
	logic [25:0] src_req_i = 26'h0000000;
	logic        on_i = 1'h0;
	logic        off_i = 1'h0;
	logic        irq_o, ack_i, push_stack_o, mem_rd_o, pc_load_o;
	logic [15:0] mem_addr_o, pc_value_o;
	logic [7:0]  mem_data_i, level_request_o;
	logic        global_enable_o, fast_enable_o;
	logic [2:0]  fast_level_o;
	logic [3:0]  ack_dly = 4'h0;
	int          error_cnt = 0;
	int          n_checks = 0;

	// Clock at 20 MHz.
	always #25 clk_i = ~clk_i;

	interrupt_level_priority_ctrl DUT (.clk_i(clk_i), .reset_i(reset_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .src_req_i(src_req_i),
		.global_int_on_instr_i(on_i), .global_int_off_instr_i(off_i), .irq_o(irq_o),
		.ack_i(ack_i), .push_stack_o(push_stack_o), .mem_rd_o(mem_rd_o),
		.mem_addr_o(mem_addr_o), .mem_data_i(mem_data_i), .pc_load_o(pc_load_o),
		.pc_value_o(pc_value_o), .level_request_o(level_request_o),
		.global_enable_o(global_enable_o), .fast_enable_o(fast_enable_o),
		.fast_level_o(fast_level_o));

	cpu_mem_model partner (.clk_i(clk_i), .irq_i(irq_o), .ack_delay_i(ack_dly), .ack_o(ack_i),
		.mem_rd_i(mem_rd_o), .mem_addr_i(mem_addr_o), .mem_data_o(mem_data_i));

	// -----------------------------------------------------------------
	// Shared tasks
	// -----------------------------------------------------------------
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic stop_test;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'h1;
		@(posedge clk_i);
		reg_wr_i <= 1'h0;
	endtask

	// Read data stand only in the cycle after the strobe.
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'h1;
		@(posedge clk_i);
		reg_rd_i <= 1'h0;
		#1 chk("rdata", reg_rdata_o, exp);
	endtask

	task automatic pulse_src(input logic [25:0] m);
		@(posedge clk_i);
		src_req_i <= m;
		@(posedge clk_i);
		src_req_i <= 26'h0000000;
	endtask

	task automatic instr(input logic on, input logic off);
		@(posedge clk_i);
		on_i <= on;
		off_i <= off;
		@(posedge clk_i);
		on_i <= 1'h0;
		off_i <= 1'h0;
	endtask

	function automatic logic [15:0] hnd(input logic [7:0] v);
		return {v ^ 8'h5a, (v + 8'h01) ^ 8'h5a};
	endfunction

	// Enables globally, then follows one whole grant through to the handler load.
	task automatic grant(input logic [7:0] vec);
		int i;
		instr(1'h1, 1'h0);
		@(negedge clk_i);
		chk("irq on", irq_o, 16'h0001);
		i = 0;
		while (push_stack_o !== 1'h1 && i < 40)
		begin
			@(negedge clk_i);
			i++;
		end
		chk("push", push_stack_o, 16'h0001);
		chk("gie", global_enable_o, 16'h0000);
		@(negedge clk_i);
		chk("irq", irq_o, 16'h0000);
		chk("mrd", mem_rd_o, 16'h0001);
		chk("vec", mem_addr_o, {8'h00, vec});
		@(negedge clk_i);
		chk("vec1", mem_addr_o, {8'h00, vec + 8'h01});
		repeat (2) @(negedge clk_i);
		chk("pcld", pc_load_o, 16'h0001);
		chk("pc", pc_value_o, hnd(vec));
	endtask

	// -----------------------------------------------------------------
	// Scenarios
	// -----------------------------------------------------------------
	task automatic t_regs;
		rd(ADDR_SYSTEM_MODE, 8'h00);
		wr(ADDR_LEVEL_MASK, 8'h5a);
		rd(ADDR_LEVEL_MASK, 8'h5a);
		wr(ADDR_LEVEL_PRIORITY, 8'h3c);
		rd(ADDR_LEVEL_PRIORITY, 8'h3c);
		wr(ADDR_LEVEL_PENDING, 8'hff);
		rd(ADDR_LEVEL_PENDING, 8'h00);
		rd(8'h20, 8'h00);
		wr(ADDR_SYSTEM_MODE, 8'h1e);
		#1 chk("fast", {fast_level_o, fast_enable_o, global_enable_o}, 16'h001e);
		rd(ADDR_SYSTEM_MODE, 8'h1e);
		wr(ADDR_SYSTEM_MODE, 8'h00);
		wr(ADDR_LEVEL_PRIORITY, 8'h00);
		wr(ADDR_LEVEL_MASK, 8'hff);
		wr(8'h04, 8'hff);
		wr(8'h05, 8'hff);
		wr(8'h06, 8'hff);
		wr(8'h07, 8'hff);
		rd(8'h07, 8'h03);
	endtask

	task automatic t_instr;
		instr(1'h1, 1'h0);
		@(negedge clk_i) chk("gie on", global_enable_o, 16'h0001);
		rd(ADDR_SYSTEM_MODE, 8'h01);
		instr(1'h0, 1'h1);
		@(negedge clk_i) chk("gie off", global_enable_o, 16'h0000);
		instr(1'h1, 1'h1);
		@(negedge clk_i) chk("gie both", global_enable_o, 16'h0000);
	endtask

	// Two sources of one level: the lower vector goes first; software clears others.
	task automatic t_order;
		ack_dly <= 4'h3;
		pulse_src(26'h0000140);
		rd(ADDR_LEVEL_PENDING, 8'h08);
		grant(8'h4c);
		wr(8'h08, 8'h40);
		grant(8'h50);
		wr(8'h09, 8'h01);
		rd(8'h09, 8'h00);
		ack_dly <= 4'h0;
	endtask

	// Level order comes from the priority register, not from the level number.
	task automatic t_prio;
		wr(ADDR_LEVEL_PRIORITY, 8'h04);
		pulse_src(26'h0400001);
		grant(8'h6c);
		wr(8'h0a, 8'h40);
		wr(ADDR_LEVEL_PRIORITY, 8'h00);
		pulse_src(26'h0400000);
		grant(8'h40);
		rd(8'h08, 8'h00);
		wr(8'h0a, 8'h40);
		wr(ADDR_LEVEL_PRIORITY, 8'h08);
		pulse_src(26'h0000009);
		grant(8'h46);
		grant(8'h40);
		rd(8'h08, 8'h00);
		wr(ADDR_LEVEL_PRIORITY, 8'h95);
		pulse_src(26'h0404050);
		grant(8'h6c);
		wr(8'h0a, 8'h40);
		grant(8'h5c);
		wr(8'h09, 8'h40);
		grant(8'h4c);
		wr(8'h08, 8'h40);
		grant(8'h48);
		wr(8'h08, 8'h10);
		rd(ADDR_LEVEL_PENDING, 8'h00);
		wr(ADDR_LEVEL_PRIORITY, 8'h00);
	endtask

	// A masked level or a disabled source never reaches the CPU.
	task automatic t_mask;
		wr(ADDR_LEVEL_MASK, 8'hef);
		pulse_src(26'h0000400);
		instr(1'h1, 1'h0);
		repeat (4) @(negedge clk_i);
		chk("masked irq", irq_o, 16'h0000);
		chk("lvl req", level_request_o, 16'h0010);
		instr(1'h0, 1'h1);
		wr(ADDR_LEVEL_MASK, 8'hff);
		grant(8'h54);
		wr(8'h09, 8'h04);
		wr(8'h05, 8'hfb);
		pulse_src(26'h0000400);
		@(negedge clk_i) chk("src off", level_request_o, 16'h0000);
		instr(1'h1, 1'h0);
		repeat (3) @(negedge clk_i);
		chk("src irq", irq_o, 16'h0000);
		rd(8'h09, 8'h04);
		instr(1'h0, 1'h1);
		wr(8'h09, 8'h04);
		wr(8'h05, 8'hff);
	endtask

	// Watchdog: the whole run needs well under two thousand cycles.
	initial
	begin
		#(50 * 4000);
		error_cnt++;
		stop_test();
	end

	// Main sequence: reset, boot load, then each scenario in turn.
	initial
	begin
		repeat (2) @(posedge clk_i);
		reset_i <= 1'h0;
		@(posedge clk_i);
		#1 chk("boot ld", pc_load_o, 16'h0001);
		chk("boot pc", pc_value_o, RESET_PC);
		chk("gie rst", global_enable_o, 16'h0000);
		t_regs();
		t_instr();
		t_order();
		t_prio();
		t_mask();
		stop_test();
	end
endmodule
